// [pkg/dee_ctrl_regs.vh]
// Register layout and timing constants for the data EEPROM control block
`ifndef DEE_CTRL_REGS_VH
`define DEE_CTRL_REGS_VH
`define DEE_CTRL_RESET 8'h00
`define DEE_BIT_TSEL 7
`define DEE_BIT_WALLOW 6
`define DEE_BIT_WSTART 5
`define DEE_BIT_MODE 4
`define DEE_BIT_SALLOW 3
`define DEE_BIT_SSTART 2
`define DEE_BIT_RALLOW 1
`define DEE_BIT_RSTART 0
// Cycle times in microseconds
`define DEE_WIPE_TIME0_US 3200
`define DEE_WIPE_TIME1_US 3700
`define DEE_STORE_TIME0_US 2200
`define DEE_STORE_TIME1_US 3000
`define DEE_CLK_MHZ 25
`define DEE_PAGE_BYTES 16
`define DEE_ADDR_W 11
`define DEE_ADDR_RESET 11'h000
`define DEE_CNT_W 17
`define DEE_CNT_ONE 17'h00001
`define DEE_CNT_ZERO 17'h00000
`endif

// [core/dee_ctrl.v]
// Data EEPROM control register and erase/write/read cycle sequencer
`timescale 1ns/100ps
`include "dee_ctrl_regs.vh"
module dee_ctrl #(
  parameter WIPE_T0 = `DEE_WIPE_TIME0_US * `DEE_CLK_MHZ,
  parameter WIPE_T1 = `DEE_WIPE_TIME1_US * `DEE_CLK_MHZ,
  parameter STORE_T0 = `DEE_STORE_TIME0_US * `DEE_CLK_MHZ,
  parameter STORE_T1 = `DEE_STORE_TIME1_US * `DEE_CLK_MHZ,
  parameter READ_T = 2
) (
  input wire clk,
  input wire rst,
  input wire ctrl_we,
  input wire [7:0] ctrl_wdata,
  output wire [7:0] ctrl_rdata,
  input wire [2:0] rom_addr_high,
  input wire [7:0] rom_addr_low,
  output reg [10:0] mem_addr,
  output wire page_mode,
  output reg wipe_active,
  output reg store_active,
  output reg read_active,
  output wire cycle_done
);
  localparam ST_IDLE = 4'h1;
  localparam ST_WIPE = 4'h2;
  localparam ST_STORE = 4'h4;
  localparam ST_READ = 4'h8;

  // Operation slots of the per-operation loop, highest priority first
  localparam OP_WIPE = 0;
  localparam OP_STORE = 1;
  localparam OP_READ = 2;
  localparam N_OPS = 3;

  reg [7:0] ctrl_r;
  reg [7:0] ctrl_nxt;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [`DEE_CNT_W-1:0] cnt_r;
  reg [`DEE_CNT_W-1:0] cnt_nxt;
  reg [`DEE_CNT_W-1:0] cnt_load;
  reg [`DEE_ADDR_W-1:0] addr_nxt;
  reg done;

  wire state_idle;
  wire state_busy;
  wire cnt_last;
  wire tsel_new;
  wire any_accept;
  wire any_drop;
  wire [N_OPS-1:0] op_allow_old;
  wire [N_OPS-1:0] op_allow_new;
  wire [N_OPS-1:0] op_start_new;
  wire [N_OPS-1:0] op_accept;
  wire [N_OPS-1:0] op_running;
  wire [N_OPS-1:0] op_drop;

  assign ctrl_rdata = ctrl_r;
  assign page_mode = ctrl_r[`DEE_BIT_MODE];
  assign cycle_done = done;

  assign state_idle = (state_r == ST_IDLE);
  assign state_busy = |op_running;
  assign cnt_last = (cnt_r <= `DEE_CNT_ONE);
  assign tsel_new = ctrl_wdata[`DEE_BIT_TSEL];
  assign any_accept = |op_accept;
  assign any_drop = |op_drop;

  // Per-operation decode of the allow and start pair
  genvar k;
  generate
    for (k = 0; k < N_OPS; k = k + 1) begin : g_op
      localparam ALLOW_BIT = (k == OP_WIPE) ? `DEE_BIT_WALLOW : (k == OP_STORE) ? `DEE_BIT_SALLOW : `DEE_BIT_RALLOW;
      localparam START_BIT = (k == OP_WIPE) ? `DEE_BIT_WSTART : (k == OP_STORE) ? `DEE_BIT_SSTART : `DEE_BIT_RSTART;
      localparam [3:0] OP_STATE = (k == OP_WIPE) ? ST_WIPE : (k == OP_STORE) ? ST_STORE : ST_READ;
      assign op_allow_old[k] = ctrl_r[ALLOW_BIT];
      assign op_allow_new[k] = ctrl_wdata[ALLOW_BIT];
      assign op_start_new[k] = ctrl_wdata[START_BIT];
      // Start sticks only if allow was already set and the same write keeps it set
      assign op_accept[k] = state_idle & ctrl_we & op_allow_old[k] & op_allow_new[k] & op_start_new[k];
      assign op_running[k] = (state_r == OP_STATE);
      // Clearing the allow bit of the running operation inhibits it
      assign op_drop[k] = op_running[k] & ctrl_we & ~op_allow_new[k];
    end
  endgenerate

  // Control register next value
  always @* begin
    ctrl_nxt = ctrl_r;
    if (state_idle) begin
      if (ctrl_we) begin
        ctrl_nxt = ctrl_wdata;
        if (!op_accept[OP_WIPE]) begin
          ctrl_nxt[`DEE_BIT_WSTART] = 1'b0;
        end
        if (!op_accept[OP_STORE]) begin
          ctrl_nxt[`DEE_BIT_SSTART] = 1'b0;
        end
        if (!op_accept[OP_READ]) begin
          ctrl_nxt[`DEE_BIT_RSTART] = 1'b0;
        end
      end
    end else if (state_busy) begin
      // A write during a cycle can only clear bits: allow bits directly, and all start bits when it inhibits the running operation
      if (ctrl_we) begin
        if (!ctrl_wdata[`DEE_BIT_WALLOW]) begin
          ctrl_nxt[`DEE_BIT_WALLOW] = 1'b0;
        end
        if (!ctrl_wdata[`DEE_BIT_SALLOW]) begin
          ctrl_nxt[`DEE_BIT_SALLOW] = 1'b0;
        end
        if (!ctrl_wdata[`DEE_BIT_RALLOW]) begin
          ctrl_nxt[`DEE_BIT_RALLOW] = 1'b0;
        end
      end
      if (any_drop) begin
        ctrl_nxt[`DEE_BIT_WSTART] = 1'b0;
        ctrl_nxt[`DEE_BIT_SSTART] = 1'b0;
        ctrl_nxt[`DEE_BIT_RSTART] = 1'b0;
      end else if (cnt_last) begin
        if (op_running[OP_WIPE]) begin
          ctrl_nxt[`DEE_BIT_WSTART] = 1'b0;
          ctrl_nxt[`DEE_BIT_WALLOW] = 1'b0;
        end
        if (op_running[OP_STORE]) begin
          ctrl_nxt[`DEE_BIT_SSTART] = 1'b0;
          ctrl_nxt[`DEE_BIT_SALLOW] = 1'b0;
        end
        if (op_running[OP_READ]) begin
          ctrl_nxt[`DEE_BIT_RSTART] = 1'b0;
        end
      end
    end
  end

  // Cycle length of the operation being started
  always @* begin
    cnt_load = `DEE_CNT_ZERO;
    if (op_accept[OP_WIPE]) begin
      cnt_load = tsel_new ? WIPE_T1[`DEE_CNT_W-1:0] : WIPE_T0[`DEE_CNT_W-1:0];
    end else if (op_accept[OP_STORE]) begin
      cnt_load = tsel_new ? STORE_T1[`DEE_CNT_W-1:0] : STORE_T0[`DEE_CNT_W-1:0];
    end else if (op_accept[OP_READ]) begin
      cnt_load = READ_T[`DEE_CNT_W-1:0];
    end
  end

  // Sequencer: wipe wins over store, store over read
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    done = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (op_accept[OP_WIPE]) begin
          state_nxt = ST_WIPE;
        end else if (op_accept[OP_STORE]) begin
          state_nxt = ST_STORE;
        end else if (op_accept[OP_READ]) begin
          state_nxt = ST_READ;
        end
        if (any_accept) begin
          cnt_nxt = cnt_load;
        end
      end
      ST_WIPE, ST_STORE, ST_READ: begin
        if (any_drop) begin
          state_nxt = ST_IDLE;
        end else if (cnt_last) begin
          state_nxt = ST_IDLE;
          cnt_nxt = `DEE_CNT_ZERO;
          done = 1'b1;
        end else begin
          cnt_nxt = cnt_r - `DEE_CNT_ONE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Address is latched as a cycle starts
  always @* begin
    addr_nxt = mem_addr;
    if (any_accept) begin
      addr_nxt = {rom_addr_high, rom_addr_low};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `DEE_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Reset abandons any running cycle
  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= `DEE_CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      mem_addr <= `DEE_ADDR_RESET;
      wipe_active <= 1'b0;
      store_active <= 1'b0;
      read_active <= 1'b0;
    end else begin
      mem_addr <= addr_nxt;
      wipe_active <= (state_nxt == ST_WIPE);
      store_active <= (state_nxt == ST_STORE);
      read_active <= (state_nxt == ST_READ);
    end
  end
endmodule

// [testbench/dee_ctrl_monitor.sv]
// Port checks for the data EEPROM control block
`timescale 1ns/100ps
module dee_ctrl_monitor (
  input wire clk,
  input wire rst,
  input wire ctrl_we,
  input wire [7:0] ctrl_wdata,
  input wire [7:0] ctrl_rdata,
  input wire page_mode,
  input wire wipe_active,
  input wire store_active,
  input wire read_active,
  input wire cycle_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_wipe_allow: assert property ($rose(wipe_active) |-> $past(ctrl_we & ctrl_rdata[6] & ctrl_wdata[5]))
    else $error("wipe without allow");
  a_store_allow: assert property ($rose(store_active) |-> $past(ctrl_we & ctrl_rdata[3] & ctrl_wdata[2]))
    else $error("store without allow");
  a_read_allow: assert property ($rose(read_active) |-> $past(ctrl_we & ctrl_rdata[1] & ctrl_wdata[0]))
    else $error("read without unlock");
  a_wipe_end: assert property (wipe_active && cycle_done |=> ctrl_rdata[6:5] == 2'b00 && !wipe_active)
    else $error("wipe end bits");
  a_store_end: assert property (store_active && cycle_done |=> ctrl_rdata[3:2] == 2'b00 && !store_active)
    else $error("store end bits");
  a_read_end: assert property (read_active && cycle_done |=> !ctrl_rdata[0] && !read_active)
    else $error("read end bit");
  a_start_tracks: assert property (ctrl_rdata[5] == wipe_active && ctrl_rdata[2] == store_active)
    else $error("start bit mismatch");
  a_mode_out: assert property (page_mode == ctrl_rdata[4])
    else $error("mode output");
  a_reset_clear: assert property ($past(rst) |-> ctrl_rdata == 8'h00 && !wipe_active && !store_active)
    else $error("reset state");
  c_wipe: cover property ($rose(wipe_active));
  c_store: cover property ($rose(store_active));
  c_read: cover property ($rose(read_active));
endmodule
bind dee_ctrl dee_ctrl_monitor u_dee_ctrl_monitor (.*);

// [testbench/dee_ctrl_tb.sv]
// Self-checking bench for the data EEPROM control block
`timescale 1ns/100ps
module dee_ctrl_tb;
  logic clk = 0, rst = 1, we = 0;
  logic [7:0] wd = 8'h00;
  wire [7:0] rd;
  wire [10:0] ma;
  wire wa, sa, ra, pm, cd;
  logic [2:0] ah = 3'h0;
  logic [7:0] al = 8'h00;
  int n_done = 0;
  int bad_count = 0, n_checks = 0, n;
  logic [31:0] t [9] = '{32'h40600600, 32'hC0E00780, 32'h080C0400, 32'h888C0580, 32'h12130212,
    32'h00200000, 32'h00040000, 32'h00010000, 32'h40200000};
  always #20 clk = ~clk;
  dee_ctrl #(.WIPE_T0(6), .WIPE_T1(7), .STORE_T0(4), .STORE_T1(5), .READ_T(2)) u_dee_ctrl (
    .clk(clk), .rst(rst), .ctrl_we(we), .ctrl_wdata(wd), .ctrl_rdata(rd), .rom_addr_high(ah),
    .rom_addr_low(al), .mem_addr(ma), .page_mode(pm), .wipe_active(wa), .store_active(sa),
    .read_active(ra), .cycle_done(cd));
  always @(posedge clk) if (!rst && cd) n_done++;
  task chk(input logic [10:0] g, input logic [10:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] d);
    @(negedge clk);
    we = 1;
    wd = d;
    @(negedge clk);
    we = 0;
  endtask
  task results;
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    results;
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    chk({3'h0, rd}, 11'h000);
    // Rows: allow write, start write, cycle length, register after
    foreach (t[i]) begin
      ah = i[2:0];
      al = 8'h30 + i[7:0];
      wr(t[i][31:24]);
      wr(t[i][23:16]);
      if (wa | sa | ra) chk(ma, {ah, al});
      n = 0;
      while ((wa | sa | ra) && n < 99) begin
        n++;
        @(negedge clk);
      end
      chk(n[10:0], {3'h0, t[i][15:8]});
      chk({3'h0, rd}, {3'h0, t[i][7:0]});
      chk({10'h000, pm}, {10'h000, t[i][4]});
    end
    // Clearing the allow bit mid store abandons it without a done pulse
    wr(8'h08);
    wr(8'h0C);
    wr(8'h00);
    chk({2'h0, sa, rd}, 11'h000);
    chk(n_done[10:0], 11'h005);
    // Reset in mid store abandons it
    wr(8'h08);
    wr(8'h0C);
    rst = 1;
    @(negedge clk);
    rst = 0;
    chk({2'h0, sa, rd}, 11'h000);
    results;
  end
endmodule
